// File: osc_top.sv
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "osc_map.svh"
// How it works
// R1: four sectors of 512 rows, 32 bits
// R2: security word loaded from otp at start
// R3: rest of otp copied out before booting; the code copies only main rows 0 to 0x7FF, not the redundant rows
// R4: 16-bit address port at 0x100200
// R5: 32-bit data port at 0x200100
// R6: 16-bit control port at 0x100300
// R7: bit 0 shuts the test access interface
// R8: bit 1 refuses link access from tiles
// R9: bit 5 boots from otp address zero
// R10: bit 7 enables the redundant rows
// R11: bits 8 to 11 lock sectors 0-3
// R12: bit 12 locks all programming
// R13: bit 13 denies test-port otp access
// R14: bit 14 blocks the debug pin
// R15: bits 21:15 readable by user software
// R16: bits 31:22 extend the user id
// R17: usercode takes user id from bits 31:22
// R18: tap has 4-bit ir, 32-bit dr
// R19: idcode gives version, part, maker fields
// R20: debug pin floats until breakpoint, then low
// R21: debug pin pulled low requests debug mode
// R22: host holds test reset low at power-up
// R23: settings act only after load completes
// R24: secure boot starts at own otp address zero
module osc_top #(
   parameter int RED_ROWS = 16,
   parameter logic [3:0] ID_VERSION = 4'h1,
   parameter logic [15:0] ID_PART = 16'h1234,
   parameter logic [10:0] ID_MAKER = 11'h2A5,
   parameter logic [11:0] SI_REV = 12'h001
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic copy_valid_o,
   output logic [10:0] copy_addr_o,
   output logic [31:0] copy_data_o,
   input wire logic copy_ready_i,
   output logic boot_go_o,
   output logic secure_boot_o,
   output logic [15:0] boot_addr_o,
   output logic jtag_en_o,
   output logic jtag_otp_en_o,
   output logic link_access_en_o,
   output logic [`OSC_IR_W-1:0] tap_ir_width_o,
   output logic [`OSC_DR_W-1:0] idcode_o,
   output logic [`OSC_DR_W-1:0] usercode_o,
   input wire logic brk_hit_i,
   input wire logic debug_n_i,
   output logic debug_n_o,
   output logic debug_n_oe_o,
   output logic debug_req_o
);
   import osc_pkg::*;

   localparam int MEM_DEPTH = 32'(`OSC_RED_END) + 1;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   osc_state_type state_q, state_d;
   logic [15:0] addr_q;
   logic [31:0] data_q;
   logic [31:0] rdat_q;
   logic [31:0] sec_q;
   logic loaded_q;
   logic refused_q;
   logic [1:0] dbg_cfg_q;
   logic [10:0] copy_idx_q;
   logic [31:0] mem_rdata;
   logic ack_q;
   logic [31:0] dat_q;
   logic dbg_s1_q, dbg_s2_q;
   osc_mem_req_type mem_req;
   osc_wb_req_type wb;

   assign wb = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   function automatic logic addr_ok(input logic [15:0] a,
                                    input logic [31:0] s);
      logic ok;
      ok = (a < `OSC_MAIN_END) ||
           (s[`OSC_B_REDUN] && a < `OSC_MAIN_END + 16'(RED_ROWS)) || // [R10]
           (a == `OSC_SEC_ROW);
      return ok;
   endfunction

   function automatic logic pgm_ok(input logic [15:0] a,
                                   input logic [31:0] s);
      logic ok;
      logic [1:0] sect;
      sect = a[`OSC_SECT_LSB+1:`OSC_SECT_LSB];
      ok = addr_ok(a, s) && !s[`OSC_B_MLOCK]; // [R12]
      if (a < `OSC_MAIN_END && s[`OSC_B_LOCK0 + 32'(sect)]) begin
         ok = 1'b0; // [R11]
      end
      return ok;
   endfunction

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire bus_req = wb.cyc && wb.stb && !ack_q;
   wire bus_wr = bus_req && wb.we;
   wire wr_addr = bus_wr && wb.adr == `OSC_REG_ADDR;
   wire wr_data = bus_wr && wb.adr == `OSC_REG_DATA;
   wire wr_ctrl = bus_wr && wb.adr == `OSC_REG_CTRL;
   wire wr_dbg = bus_wr && wb.adr == `OSC_REG_DBG;
   wire idle = state_q == ST_IDLE;
   wire start_pgm = wr_ctrl && wb.sel[0] && wb.dat[`OSC_C_PGM] && idle;
   wire start_rd = wr_ctrl && wb.sel[0] && wb.dat[`OSC_C_RD] && idle &&
                   !start_pgm;
   wire pgm_allowed = pgm_ok(addr_q, sec_q);
   wire rd_allowed = addr_ok(addr_q, sec_q);
   wire refuse_now = (start_pgm && !pgm_allowed) ||
                     (start_rd && !rd_allowed) ||
                     (wr_ctrl && wb.sel[0] && !idle &&
                      (wb.dat[`OSC_C_PGM] || wb.dat[`OSC_C_RD]));
   wire clr_refused = wr_ctrl && wb.sel[0] && wb.dat[`OSC_C_CLR];

   wire [31:0] status_word = {28'h0000000, loaded_q, 1'b0, refused_q,
                              !idle};
   // software sees only the general purpose and user id fields of the
   // word; the lock and enable bits stay hidden
   wire [31:0] sec_view = {sec_q[`OSC_UID_MSB:`OSC_UID_LSB],
                           sec_q[`OSC_GP_MSB:`OSC_GP_LSB],
                           15'h0000}; // [R15] [R16]

   logic [31:0] rd_mux;
   always_comb begin
      unique case (wb.adr)
         `OSC_REG_ADDR: rd_mux = {16'h0000, addr_q}; // [R4]
         `OSC_REG_DATA: rd_mux = data_q; // [R5]
         `OSC_REG_CTRL: rd_mux = status_word; // [R6]
         `OSC_REG_SEC: rd_mux = sec_view;
         `OSC_REG_RDAT: rd_mux = rdat_q;
         `OSC_REG_IDC: rd_mux = idcode_o;
         `OSC_REG_USR: rd_mux = usercode_o;
         `OSC_REG_DBG: rd_mux = {30'h00000000, dbg_cfg_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // ---------------------------------------------------------------
   // wishbone answer, one cycle after the strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= bus_req;
         dat_q <= rd_mux;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ---------------------------------------------------------------
   // port registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_q <= 16'h0000;
         data_q <= 32'h00000000;
         dbg_cfg_q <= 2'h0;
         refused_q <= 1'b0;
      end else begin
         if (wr_addr && wb.sel[0]) addr_q[7:0] <= wb.dat[7:0]; // [R4]
         if (wr_addr && wb.sel[1]) addr_q[15:8] <= wb.dat[15:8];
         for (int i = 0; i < 4; i++) begin
            if (wr_data && wb.sel[i]) begin
               data_q[i*8 +: 8] <= wb.dat[i*8 +: 8]; // [R5]
            end
         end
         if (wr_dbg && wb.sel[0]) dbg_cfg_q <= wb.dat[1:0];
         // a refusal in the same cycle as the clear stays set
         if (refuse_now) refused_q <= 1'b1;
         else if (clr_refused) refused_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // load, copy and programming sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      mem_req = '{we: 1'b0, addr: 12'h000, wdata: 32'h00000000};
      unique case (state_q)
         ST_LOAD_RD: begin
            mem_req.addr = 12'(`OSC_SEC_ROW); // [R2]
            state_d = ST_LOAD_WT;
         end
         ST_LOAD_WT: state_d = ST_COPY_RD;
         ST_COPY_RD: begin
            mem_req.addr = {1'b0, copy_idx_q}; // [R3]
            state_d = ST_COPY_OUT;
         end
         ST_COPY_OUT: begin
            mem_req.addr = {1'b0, copy_idx_q};
            if (copy_ready_i) begin
               state_d = (copy_idx_q == 11'h7FF) ? ST_IDLE : ST_COPY_RD;
            end
         end
         ST_IDLE: begin
            if (start_pgm && pgm_allowed) state_d = ST_PGM_RD;
            else if (start_rd && rd_allowed) state_d = ST_RD;
         end
         ST_PGM_RD: begin
            mem_req.addr = addr_q[11:0];
            state_d = ST_PGM_WT;
         end
         ST_PGM_WT: begin
            mem_req.addr = addr_q[11:0];
            state_d = ST_PGM_WR;
         end
         ST_PGM_WR: begin
            // burning only ever sets bits, never clears them
            mem_req = '{we: 1'b1, addr: addr_q[11:0],
                        wdata: mem_rdata | data_q}; // [R6]
            state_d = ST_IDLE;
         end
         ST_RD: begin
            mem_req.addr = addr_q[11:0];
            state_d = ST_RD_WT;
         end
         ST_RD_WT: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_LOAD_RD;
         sec_q <= 32'h00000000;
         loaded_q <= 1'b0;
         copy_idx_q <= 11'h000;
         rdat_q <= 32'h00000000;
      end else begin
         state_q <= state_d;
         if (state_q == ST_LOAD_WT) sec_q <= mem_rdata; // [R2]
         if (state_q == ST_COPY_OUT && copy_ready_i) begin
            copy_idx_q <= copy_idx_q + 11'h001;
            if (copy_idx_q == 11'h7FF) loaded_q <= 1'b1; // [R23]
         end
         if (state_q == ST_RD_WT) rdat_q <= mem_rdata;
         // a burnt security word takes effect only at the next load
      end
   end

   osc_otp_mem #(
      .DEPTH(MEM_DEPTH)
   ) u_mem (
      .clk_i(clk_i),
      .req_i(mem_req),
      .rdata_o(mem_rdata)
   ); // [R1] [R10]

   // ---------------------------------------------------------------
   // copy stream to sram
   // ---------------------------------------------------------------
   assign copy_valid_o = state_q == ST_COPY_OUT; // [R3]
   assign copy_addr_o = copy_idx_q;
   assign copy_data_o = mem_rdata;

   // ---------------------------------------------------------------
   // boot and access gates, all held closed until loaded
   // ---------------------------------------------------------------
   assign boot_go_o = loaded_q; // [R23]
   assign secure_boot_o = loaded_q && sec_q[`OSC_B_SBOOT]; // [R9]
   assign boot_addr_o = 16'h0000; // [R24]
   assign jtag_en_o = loaded_q && !sec_q[`OSC_B_NOJTAG]; // [R7]
   assign jtag_otp_en_o = jtag_en_o && !sec_q[`OSC_B_NOJOTP]; // [R13]
   assign link_access_en_o = loaded_q && !sec_q[`OSC_B_NOLINK]; // [R8]

   // ---------------------------------------------------------------
   // identification words
   // ---------------------------------------------------------------
   // identity fields are parameters with arbitrary neutral defaults
   assign tap_ir_width_o = `OSC_IR_W'(`OSC_IR_W); // [R18]
   assign idcode_o = {ID_VERSION, ID_PART, ID_MAKER, 1'b1}; // [R19]
   // this instance stands for tile 0, so its own word feeds the id
   assign usercode_o = {sec_q[`OSC_UID_MSB:`OSC_UID_LSB], 10'h000,
                        SI_REV}; // [R17]

   // ---------------------------------------------------------------
   // debug synchronisation pin
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dbg_s1_q <= 1'b1;
         dbg_s2_q <= 1'b1;
      end else begin
         dbg_s1_q <= debug_n_i;
         dbg_s2_q <= dbg_s1_q;
      end
   end

   wire dbg_allowed = loaded_q && !sec_q[`OSC_B_NODBG]; // [R14]
   assign debug_n_o = 1'b0;
   assign debug_n_oe_o = dbg_allowed && dbg_cfg_q[`OSC_D_OUT] &&
                         brk_hit_i; // [R20]
   // own drive is masked from the request only while it lasts, not in the cycles the synchroniser still shows it low
   assign debug_req_o = dbg_allowed && dbg_cfg_q[`OSC_D_IN] &&
                        !dbg_s2_q && !debug_n_oe_o; // [R21]
endmodule

// File: osc_map.svh
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OSC_REG_ADDR 8'h00
`define OSC_REG_DATA 8'h04
`define OSC_REG_CTRL 8'h08
`define OSC_REG_SEC 8'h0C
`define OSC_REG_RDAT 8'h10
`define OSC_REG_IDC 8'h14
`define OSC_REG_USR 8'h18
`define OSC_REG_DBG 8'h1C

// ---------------------------------------------------------------
// port resource identifiers
// ---------------------------------------------------------------
`define OSC_RES_ADDR 24'h100200
`define OSC_RES_DATA 24'h200100
`define OSC_RES_CTRL 24'h100300

// ---------------------------------------------------------------
// otp geometry
// ---------------------------------------------------------------
`define OSC_SECTORS 4
`define OSC_ROWS 512
`define OSC_MAIN_END 16'h0800
`define OSC_RED_END 16'h0810
`define OSC_SEC_ROW 16'h0810
`define OSC_SECT_LSB 9

// ---------------------------------------------------------------
// security word bits
// ---------------------------------------------------------------
`define OSC_B_NOJTAG 0
`define OSC_B_NOLINK 1
`define OSC_B_SBOOT 5
`define OSC_B_REDUN 7
`define OSC_B_LOCK0 8
`define OSC_B_MLOCK 12
`define OSC_B_NOJOTP 13
`define OSC_B_NODBG 14
`define OSC_GP_MSB 21
`define OSC_GP_LSB 15
`define OSC_UID_MSB 31
`define OSC_UID_LSB 22

// ---------------------------------------------------------------
// control and status bits
// ---------------------------------------------------------------
`define OSC_C_PGM 0
`define OSC_C_RD 1
`define OSC_C_CLR 2
`define OSC_S_BUSY 0
`define OSC_S_REFUSED 1
`define OSC_S_LOADED 3
`define OSC_D_OUT 0
`define OSC_D_IN 1

// ---------------------------------------------------------------
// test access port sizes
// ---------------------------------------------------------------
`define OSC_IR_W 4
`define OSC_DR_W 32

`endif

// File: osc_pkg.sv
package osc_pkg;
   typedef enum logic [3:0] {
      ST_LOAD_RD, ST_LOAD_WT, ST_COPY_RD, ST_COPY_OUT, ST_IDLE,
      ST_PGM_RD, ST_PGM_WT, ST_PGM_WR, ST_RD, ST_RD_WT
   } osc_state_type;

   typedef struct packed {
      logic we;
      logic [11:0] addr;
      logic [31:0] wdata;
   } osc_mem_req_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } osc_wb_req_type;
endpackage

// File: osc_otp_mem.sv
`timescale 1ns/100ps
module osc_otp_mem #(
   parameter int DEPTH = 2065
) (
   input wire logic clk_i,
   input osc_pkg::osc_mem_req_type req_i,
   output logic [31:0] rdata_o
);
   import osc_pkg::*;

   // an unburnt otp reads as all zero; no reset, since burnt rows must
   // survive a reset of the block
   logic [31:0] cell_q [0:DEPTH-1] = '{default: 32'h00000000};
   always_ff @(posedge clk_i) begin
      if (req_i.we) begin
         cell_q[req_i.addr] <= req_i.wdata;
      end
      rdata_o <= cell_q[req_i.addr];
   end
endmodule

// File: osc_top_checker.sv
`timescale 1ns/100ps
module osc_top_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic copy_valid_o,
   input wire logic [10:0] copy_addr_o,
   input wire logic copy_ready_i,
   input wire logic secure_boot_o,
   input wire logic [15:0] boot_addr_o,
   input wire logic jtag_en_o,
   input wire logic jtag_otp_en_o,
   input wire logic [3:0] tap_ir_width_o,
   input wire logic [31:0] usercode_o,
   input wire logic brk_hit_i,
   input wire logic debug_n_o,
   input wire logic debug_n_oe_o,
   input wire logic debug_req_o
);
   // ----------------------------------------
   // port relations
   // ----------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer late");
   property p_otp_gate;
      jtag_otp_en_o |-> jtag_en_o;
   endproperty
   a_otp_gate: assert property (p_otp_gate) else $error("otp gate");
   property p_ir;
      tap_ir_width_o == 4'h4;
   endproperty
   a_ir: assert property (p_ir) else $error("ir width");
   property p_uc;
      usercode_o[21:12] == 10'h000;
   endproperty
   a_uc: assert property (p_uc) else $error("usercode gap");
   property p_sboot;
      secure_boot_o |-> boot_addr_o == 16'h0000;
   endproperty
   a_sboot: assert property (p_sboot) else $error("boot addr");
   property p_dbg_out;
      debug_n_oe_o |-> brk_hit_i && !debug_n_o;
   endproperty
   a_dbg_out: assert property (p_dbg_out) else $error("dbg out");
   property p_dbg_in;
      debug_req_o |-> !debug_n_oe_o;
   endproperty
   a_dbg_in: assert property (p_dbg_in) else $error("dbg in");
   property p_hold;
      copy_valid_o && !copy_ready_i |=> copy_valid_o && $stable(copy_addr_o);
   endproperty
   a_hold: assert property (p_hold) else $error("copy hold");
   property p_step;
      copy_valid_o && copy_ready_i && copy_addr_o != 11'h7FF |=>
         !copy_valid_o ##1
         (copy_valid_o && copy_addr_o == $past(copy_addr_o, 2) + 11'h1);
   endproperty
   a_step: assert property (p_step) else $error("copy step");
   c_copy: cover property (copy_valid_o && copy_ready_i);
   c_ack: cover property (wb_ack_o);
   c_sboot: cover property (secure_boot_o);
endmodule
bind osc_top osc_top_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .copy_valid_o(copy_valid_o), .copy_addr_o(copy_addr_o),
   .copy_ready_i(copy_ready_i), .secure_boot_o(secure_boot_o),
   .boot_addr_o(boot_addr_o), .jtag_en_o(jtag_en_o),
   .jtag_otp_en_o(jtag_otp_en_o), .tap_ir_width_o(tap_ir_width_o),
   .usercode_o(usercode_o), .brk_hit_i(brk_hit_i), .debug_n_o(debug_n_o),
   .debug_n_oe_o(debug_n_oe_o), .debug_req_o(debug_req_o));

// File: osc_sram_sink.sv
`timescale 1ns/100ps
module osc_sram_sink (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic copy_valid_i,
   input wire logic [10:0] copy_addr_i,
   input wire logic [31:0] copy_data_i,
   output logic copy_ready_o,
   output int words_o,
   output int order_err_o,
   output logic [31:0] xsum_o
);
   logic [1:0] cnt_q;
   // slow mode stalls three cycles of four
   assign copy_ready_o = !slow_i || cnt_q == 2'h3;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 2'h0;
         words_o <= 0;
         order_err_o <= 0;
         xsum_o <= 32'h00000000;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         if (copy_valid_i && copy_ready_o) begin
            words_o <= words_o + 1;
            xsum_o <= xsum_o ^ copy_data_i;
            if (copy_addr_i !== 11'(words_o)) begin
               order_err_o <= order_err_o + 1;
            end
         end
      end
   end
endmodule

// File: tb_osc_top.sv
`timescale 1ns/100ps
`include "osc_map.svh"
module tb_osc_top;
   localparam logic [3:0] VER = 4'h3; // arbitrary identity values
   localparam logic [15:0] PART = 16'h0C0A;
   localparam logic [10:0] MAKER = 11'h155;
   localparam logic [11:0] SIREV = 12'h00B;
   logic clk_i;
   logic rst_i = 1, cyc = 0, stb = 0, we = 0, brk = 0, drv_n = 1, slow = 1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rd, dat_o, uc, idc, cdat, xsum;
   logic ack, cval, crdy, bgo, sboot, jen, joen, len, dn_o, doe, dreq;
   logic [10:0] caddr;
   logic [15:0] baddr;
   logic [3:0] irw;
   int fails = 0, num_checks = 0, words, oerr;
   // pulled-up pin: device only ever pulls it low
   wire pin = (doe ? dn_o : 1'b1) & drv_n;
   osc_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
      .SI_REV(SIREV)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .copy_valid_o(cval), .copy_addr_o(caddr), .copy_data_o(cdat),
      .copy_ready_i(crdy), .boot_go_o(bgo), .secure_boot_o(sboot),
      .boot_addr_o(baddr), .jtag_en_o(jen), .jtag_otp_en_o(joen),
      .link_access_en_o(len), .tap_ir_width_o(irw), .idcode_o(idc),
      .usercode_o(uc), .brk_hit_i(brk), .debug_n_i(pin), .debug_n_o(dn_o),
      .debug_n_oe_o(doe), .debug_req_o(dreq));
   osc_sram_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
      .copy_valid_i(cval), .copy_addr_i(caddr), .copy_data_i(cdat),
      .copy_ready_o(crdy), .words_o(words), .order_err_o(oerr),
      .xsum_o(xsum));
   initial begin
      clk_i = 0;
      forever #2 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, exp, input string m);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic stop_test;
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         fails++;
         stop_test();
      end
      rd = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic wait_idle;
      repeat (20) begin
         wb(0, `OSC_REG_CTRL, 0);
         if (rd[0] === 1'b0) break;
      end
      if (rd[0] !== 1'b0) begin
         fails++;
         stop_test();
      end
   endtask
   task automatic do_reset;
      rst_i <= 1;
      repeat (6) @(posedge clk_i);
      check({29'h0, ack, cval, doe}, 32'h0, "reset outputs");
      rst_i <= 0;
   endtask
   task automatic wait_boot;
      int n;
      n = 0;
      while (bgo !== 1'b1 && n < 20000) begin
         @(posedge clk_i);
         n++;
      end
      if (bgo !== 1'b1) begin
         fails++;
         stop_test();
      end
   endtask
   task automatic t_early;
      wb(1, `OSC_REG_CTRL, 32'h1);
      wb(0, `OSC_REG_CTRL, 0);
      check({30'h0, rd[3], rd[1]}, 32'h1, "early program");
   endtask
   task automatic t_copy;
      wait_boot();
      check(32'(words), 32'd2048, "copied words");
      check(32'(oerr), 32'h0, "copy order");
      check(xsum, 32'h0, "blank copy data");
      wb(0, `OSC_REG_CTRL, 0);
      check({31'h0, rd[3]}, 32'h1, "loaded");
   endtask
   task automatic t_regs;
      wb(0, `OSC_REG_IDC, 0);
      check(rd, {VER, PART, MAKER, 1'b1}, "idcode");
      check(idc, {VER, PART, MAKER, 1'b1}, "idcode pins");
      wb(0, 8'h20, 0);
      check(rd, 32'h0, "unmapped");
      check({28'h0, irw}, 32'h4, "ir width");
      check({10'h0, uc[21:0]}, {20'h0, SIREV}, "usercode low");
      wb(1, `OSC_REG_CTRL, 32'h4);
      wb(1, `OSC_REG_ADDR, 32'h800);
      wb(1, `OSC_REG_CTRL, 32'h2);
      wb(0, `OSC_REG_CTRL, 0);
      check({31'h0, rd[1]}, 32'h1, "redundant off");
   endtask
   task automatic t_program;
      wb(1, `OSC_REG_CTRL, 32'h4);
      wb(1, `OSC_REG_ADDR, 32'h810);
      wb(1, `OSC_REG_DATA, 32'hFFFFFFFF);
      wb(1, `OSC_REG_CTRL, 32'h1);
      wait_idle();
      wb(1, `OSC_REG_CTRL, 32'h2);
      wait_idle();
      wb(0, `OSC_REG_RDAT, 0);
      check(rd, 32'hFFFFFFFF, "programmed word");
      wb(1, `OSC_REG_ADDR, 32'h5);
      wb(1, `OSC_REG_DATA, 32'h5A5AC3C3);
      wb(1, `OSC_REG_CTRL, 32'h1);
      wait_idle();
   endtask
   task automatic t_debug;
      wb(1, `OSC_REG_DBG, 32'h1);
      check({31'h0, doe}, 32'h0, "pin floats");
      brk <= 1;
      @(posedge clk_i);
      check({30'h0, doe, pin}, 32'h2, "pin driven low");
      brk <= 0;
      wb(1, `OSC_REG_DBG, 32'h2);
      drv_n <= 0;
      repeat (4) @(posedge clk_i);
      check({31'h0, dreq}, 32'h1, "debug request");
      drv_n <= 1;
      repeat (4) @(posedge clk_i);
      check({31'h0, dreq}, 32'h0, "request ends");
   endtask
   task automatic t_locked;
      wb(0, `OSC_REG_SEC, 0);
      check(rd, 32'hFFFF8000, "security view");
      check({28'h0, jen, joen, len, sboot}, 32'h1, "gates");
      check({22'h0, uc[31:22]}, 32'h3FF, "usercode id");
      check({16'h0, baddr}, 32'h0, "boot address");
      check(xsum, 32'h5A5AC3C3, "copied data");
      wb(1, `OSC_REG_CTRL, 32'h4);
      wb(1, `OSC_REG_ADDR, 32'h0);
      wb(1, `OSC_REG_DATA, 32'h1);
      wb(1, `OSC_REG_CTRL, 32'h1);
      wb(0, `OSC_REG_CTRL, 0);
      check({31'h0, rd[1]}, 32'h1, "master lock");
      wb(1, `OSC_REG_CTRL, 32'h4);
      wb(0, `OSC_REG_CTRL, 0);
      check({31'h0, rd[1]}, 32'h0, "refused clear");
      wb(1, `OSC_REG_ADDR, 32'h800);
      wb(1, `OSC_REG_CTRL, 32'h2);
      wait_idle();
      wb(0, `OSC_REG_CTRL, 0);
      check({31'h0, rd[1]}, 32'h0, "redundant on");
      wb(1, `OSC_REG_DBG, 32'h3);
      brk <= 1;
      drv_n <= 0;
      repeat (4) @(posedge clk_i);
      check({30'h0, doe, dreq}, 32'h0, "debug blocked");
   endtask
   initial begin
      do_reset();
      t_early();
      t_copy();
      t_regs();
      t_program();
      t_debug();
      slow <= 0;
      do_reset();
      wait_boot();
      t_locked();
      stop_test();
   end
   initial begin
      #160000;
      fails++;
      stop_test();
   end
endmodule
